// File: verilog/interval_timer_pkg.sv
// constants for the periodic interval timer
package interval_timer_pkg;
   localparam logic [3:0]  OFF_MODE      = 4'h0;
   localparam logic [3:0]  OFF_STATUS    = 4'h4;
   localparam logic [3:0]  OFF_VALUE_ACK = 4'h8;
   localparam logic [3:0]  OFF_VALUE_IMG = 4'hc;
   localparam int          COUNT_W       = 20;
   localparam int          TALLY_W       = 12;
   localparam int          PRESCALE_W    = 4;
   localparam logic [3:0]  PRESCALE_LAST = 4'hf;
   localparam logic [19:0] LIMIT_RESET   = 20'hfffff;
   localparam int          LIMIT_LSB     = 0;
   localparam int          TALLY_LSB     = 20;
   localparam int          TIMER_ON_BIT  = 24;
   localparam int          IRQ_EN_BIT    = 25;
   localparam int          FLAG_BIT      = 0;
endpackage

// File: verilog/periodic_interval_timer.sv
// periodic interval timer with apb register slave
// What this block does
// R01 - holds a 20-bit interval count and a 12-bit overflow tally
// R02 - both counters advance at master clock divided by sixteen
// R03 - count rises from zero; at limit returns to zero, tally plus one
// R04 - limit reached sets flag; interrupt only while irq enable is one
// R05 - writing a new limit neither resets nor restarts the counters
// R06 - value read returns counters, clears tally and flag
// R07 - tally holds intervals completed since the last value read
// R08 - image read returns counters with no side effect
// R09 - timer enable resets low; changes apply only while count is zero
// R10 - after disable count runs to limit, returns to zero, then stops
// R11 - both counters freeze while the core is in debug state
// R12 - limit sits in mode bits 19..0; period is limit plus one ticks
// R13 - mode bit 24 is timer enable
// R14 - mode bit 25 is interrupt enable gating the flag onto the irq
// R15 - value words: count in 19..0, tally in 31..20; flag in status bit 0
// R16 - tally wraps from its maximum to zero without a value read
`timescale 1ns/1ps
`default_nettype none
module periodic_interval_timer #(
   parameter int COUNT_W    = interval_timer_pkg::COUNT_W,   // interval counter width
   parameter int TALLY_W    = interval_timer_pkg::TALLY_W,   // overflow tally width
   parameter int PRESCALE_W = interval_timer_pkg::PRESCALE_W // divider is two to this power
) (
   input  wire logic        I_CLK,
   input  wire logic        I_RST_N,
   input  wire logic        I_DEBUG_HALT,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [31:0] I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic [31:0]      O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   output logic             O_IRQ
);
   // timing in short: the prescaler free-runs from reset and gives one tick
   // every sixteen clocks; each tick moves the interval counter while the
   // timer runs; the tick on which the count equals the limit is a wrap,
   // which returns the count to zero, bumps the tally and raises the flag.
   // the interrupt follows the gated flag one clock later.

   // prescaler phase; it only moves while the core runs
   logic [PRESCALE_W-1:0] presc_q;

   // interval counter and the tally of completed intervals
   logic [COUNT_W-1:0]    count_q;
   logic [TALLY_W-1:0]    tally_q;

   // interval flag, shown in the status word
   logic                  flag_q;

   // mode fields as software last wrote them
   logic [COUNT_W-1:0]    limit_q;
   logic                  on_req_q;
   logic                  irq_en_q;

   // enable as the counter obeys it, which lags the mode bit
   logic                  running_q;

   // a wrap that landed on the edge where read data was captured
   logic                  wrap_cap_q;

   // per-clock strobes of the counting path
   logic                  tick;
   logic                  step;
   logic                  wrap;
   logic                  at_zero;

   // bus phase strobes
   logic                  acc;
   logic                  setup_rd;
   logic                  wr;
   logic                  rd;

   // register hits and their qualified strobes
   logic                  hit_mode;
   logic                  hit_status;
   logic                  hit_ack;
   logic                  hit_image;
   logic                  mapped;
   logic                  wr_mode;
   logic                  rd_ack;

   // read words as they would be presented
   logic [3:0]            offs;
   logic [31:0]           mode_word;
   logic [31:0]           status_word;
   logic [31:0]           value_word;
   logic [31:0]           rdata;

   // decode a word offset into the register window
   function automatic logic is_reg(input logic [31:0] a, input logic [3:0] off);
      is_reg = (a[31:4] == 28'h0000000) && (a[3:0] == off);
   endfunction

   // next count on a counting step: zero at a wrap, else one up
   function automatic logic [COUNT_W-1:0] next_count(input logic [COUNT_W-1:0] c, input logic w);
      next_count = w ? {COUNT_W{1'b0}} : c + COUNT_W'(1);
   endfunction

   // tally plus the wraps given; past its maximum it rolls over to zero
   function automatic logic [TALLY_W-1:0] add_wraps(input logic [TALLY_W-1:0] t, input logic a, input logic b);
      add_wraps = t + TALLY_W'(a) + TALLY_W'(b);
   endfunction

   // value and image share one layout, count low and tally high
   function automatic logic [31:0] pack_value(input logic [COUNT_W-1:0] c, input logic [TALLY_W-1:0] t);
      pack_value = 32'h00000000;
      pack_value[interval_timer_pkg::LIMIT_LSB +: COUNT_W] = c;
      pack_value[interval_timer_pkg::TALLY_LSB +: TALLY_W] = t;
   endfunction

   // apb phases: single-cycle access phase, data captured in setup
   assign acc      = I_PSEL & I_PENABLE;
   assign setup_rd = I_PSEL & ~I_PENABLE & ~I_PWRITE;
   assign wr       = acc & I_PWRITE;
   assign rd       = acc & ~I_PWRITE;
   assign offs     = I_PADDR[3:0];

   // register hits; anything else in the address is a hole
   assign hit_mode   = is_reg(I_PADDR, interval_timer_pkg::OFF_MODE);
   assign hit_status = is_reg(I_PADDR, interval_timer_pkg::OFF_STATUS);
   assign hit_ack    = is_reg(I_PADDR, interval_timer_pkg::OFF_VALUE_ACK);
   assign hit_image  = is_reg(I_PADDR, interval_timer_pkg::OFF_VALUE_IMG);
   assign mapped     = hit_mode | hit_status | hit_ack | hit_image;
   assign wr_mode    = wr & hit_mode;
   assign rd_ack     = rd & hit_ack; // [R06]

   // never a wait state; holes answer with an error and no side effect
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = acc & ~mapped;

   // debug halt freezes the prescaler so no tick is lost or gained
   assign tick    = (presc_q == PRESCALE_W'(interval_timer_pkg::PRESCALE_LAST)) & ~I_DEBUG_HALT; // [R02] [R11]
   assign step    = tick & running_q;
   assign at_zero = (count_q == {COUNT_W{1'b0}});
   assign wrap    = step & (count_q == limit_q); // [R03] [R12]

   // a limit written below the running count is only met after the count
   // rolls over its full width; software should change the limit at zero.

   // master clock divider by sixteen
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         presc_q <= {PRESCALE_W{1'b0}};
      end else if (!I_DEBUG_HALT) begin
         presc_q <= presc_q + PRESCALE_W'(1); // [R02] [R11]
      end
   end

   // mode register; limit write leaves the counters alone
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         limit_q  <= COUNT_W'(interval_timer_pkg::LIMIT_RESET);
         on_req_q <= 1'b0; // [R09]
         irq_en_q <= 1'b0;
      end else if (wr_mode) begin
         limit_q  <= I_PWDATA[interval_timer_pkg::LIMIT_LSB +: COUNT_W]; // [R05] [R12]
         on_req_q <= I_PWDATA[interval_timer_pkg::TIMER_ON_BIT]; // [R13]
         irq_en_q <= I_PWDATA[interval_timer_pkg::IRQ_EN_BIT]; // [R14]
      end
   end

   // enable takes effect only at count zero, so a disable finishes the interval;
   // a step leaving zero keeps the old state so the interval is not cut short
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         running_q <= 1'b0;
      end else if (at_zero && !step) begin
         running_q <= on_req_q; // [R09] [R10]
      end else if (wrap) begin
         running_q <= on_req_q; // [R10]
      end
   end

   // interval counter; frozen between ticks and while stopped
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         count_q <= {COUNT_W{1'b0}};
      end else if (step) begin
         count_q <= next_count(count_q, wrap); // [R01] [R03]
      end
   end

   // read data is captured one edge before the acknowledge clears the tally;
   // a wrap on the capture edge is not in the snapshot and must survive
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         wrap_cap_q <= 1'b0;
      end else if (setup_rd) begin
         wrap_cap_q <= wrap; // [R07]
      end
   end

   // overflow tally; the acknowledge keeps only wraps the reader has not seen
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         tally_q <= {TALLY_W{1'b0}};
      end else if (rd_ack) begin
         tally_q <= add_wraps({TALLY_W{1'b0}}, wrap_cap_q, wrap); // [R06] [R07]
      end else if (wrap) begin
         tally_q <= add_wraps(tally_q, 1'b1, 1'b0); // [R01] [R16]
      end
   end

   // interval flag: set wins over the read clear, unseen wraps keep it up
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         flag_q <= 1'b0;
      end else if (wrap) begin
         flag_q <= 1'b1; // [R04]
      end else if (rd_ack) begin
         flag_q <= wrap_cap_q; // [R06]
      end
   end

   // register words; image and value are identical, only side effects differ
   always_comb begin
      mode_word = 32'h00000000;
      mode_word[interval_timer_pkg::LIMIT_LSB +: COUNT_W] = limit_q; // [R12]
      mode_word[interval_timer_pkg::TIMER_ON_BIT] = on_req_q; // [R13]
      mode_word[interval_timer_pkg::IRQ_EN_BIT]   = irq_en_q; // [R14]
      status_word = 32'h00000000;
      status_word[interval_timer_pkg::FLAG_BIT] = flag_q; // [R15]
      value_word = pack_value(count_q, tally_q); // [R08] [R15]
   end

   // read mux; holes read as zero
   always_comb begin
      rdata = 32'h00000000;
      case (offs)
         interval_timer_pkg::OFF_MODE: begin
            rdata = mode_word;
         end
         interval_timer_pkg::OFF_STATUS: begin
            rdata = status_word;
         end
         interval_timer_pkg::OFF_VALUE_ACK,
         interval_timer_pkg::OFF_VALUE_IMG: begin
            rdata = value_word;
         end
         default: begin
            rdata = 32'h00000000;
         end
      endcase
      if (!mapped) begin
         rdata = 32'h00000000;
      end
   end

   // read data registered in the setup cycle so it is stable in the access phase;
   // the price is a snapshot one clock old, which the tally logic accounts for
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_PRDATA <= 32'h00000000;
      end else if (setup_rd) begin
         O_PRDATA <= rdata;
      end
   end

   // interrupt is a registered copy of flag gated by enable, free of decode glitches
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         O_IRQ <= 1'b0;
      end else begin
         O_IRQ <= irq_en_q & flag_q; // [R04] [R14]
      end
   end
endmodule
`default_nettype wire

// File: sim/interval_timer_props.sv
// port assertions for the periodic interval timer
`timescale 1ns/1ps
`default_nettype none
module interval_timer_props (
   input wire logic        I_CLK,
   input wire logic        I_RST_N,
   input wire logic        I_DEBUG_HALT,
   input wire logic        I_PSEL,
   input wire logic        I_PENABLE,
   input wire logic        I_PWRITE,
   input wire logic [31:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [31:0] O_PRDATA,
   input wire logic        O_PREADY,
   input wire logic        O_PSLVERR,
   input wire logic        O_IRQ
);
   logic [31:0] mode_q;
   wire logic acc = I_PSEL && I_PENABLE;
   wire logic bad = !(I_PADDR inside {32'h0, 32'h4, 32'h8, 32'hc});
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   // shadow of the mode word, since the checker cannot see inside
   always_ff @(posedge I_CLK or negedge I_RST_N)
      if (!I_RST_N) mode_q <= 32'h000fffff;
      else if (acc && I_PWRITE && I_PADDR == 32'h0) mode_q <= I_PWDATA & 32'h030fffff;
   chk_ready_high: assert property (O_PREADY) else $error("pready low");
   chk_err_decode: assert property (acc |-> O_PSLVERR == bad) else $error("slave error wrong");
   chk_err_idle: assert property (!acc |-> !O_PSLVERR) else $error("error outside access");
   chk_mode_back: assert property (acc && !I_PWRITE && I_PADDR == 32'h0 |-> O_PRDATA == mode_q)
      else $error("mode readback wrong");
   chk_status_bits: assert property (acc && !I_PWRITE && I_PADDR == 32'h4 |-> O_PRDATA[31:1] == 31'h0)
      else $error("status spare bits set");
   chk_hole_zero: assert property (acc && !I_PWRITE && bad |-> O_PRDATA == 32'h0) else $error("hole read nonzero");
   chk_irq_gated: assert property (!mode_q[25] |=> !O_IRQ) else $error("irq while masked");
   chk_irq_rise: assert property ($rose(O_IRQ) |-> $past(mode_q[25])) else $error("irq rose unmasked");
endmodule
bind periodic_interval_timer interval_timer_props chk_i (.*);
`default_nettype wire

// File: sim/periodic_interval_timer_bench.sv
// self-checking bench for the periodic interval timer
`timescale 1ns/1ps
`default_nettype none
module periodic_interval_timer_bench;
   localparam logic [31:0] ALL = 32'hffffffff, TAL = 32'hfff00000;
   logic        I_CLK = 1'b0, I_RST_N = 1'b0, I_DEBUG_HALT = 1'b0;
   logic        I_PSEL = 1'b0, I_PENABLE = 1'b0, I_PWRITE = 1'b0;
   logic [31:0] I_PADDR = 32'h0, I_PWDATA = 32'h0, O_PRDATA, exp_q[$], msk_q[$];
   logic        O_PREADY, O_PSLVERR, O_IRQ;
   int          bad_count = 0, comparisons = 0, k;
   periodic_interval_timer uut (.I_CLK, .I_RST_N, .I_DEBUG_HALT, .I_PSEL, .I_PENABLE, .I_PWRITE,
      .I_PADDR, .I_PWDATA, .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_IRQ);
   initial forever #20 I_CLK = ~I_CLK;
   task automatic complete_run;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // request held until pready is seen high at a rising edge
   task automatic xfer(input logic w, input logic [31:0] a, d);
      I_PSEL <= 1'b1; I_PWRITE <= w; I_PADDR <= a; I_PWDATA <= d;
      @(posedge I_CLK) I_PENABLE <= 1'b1;
      do @(posedge I_CLK); while (O_PREADY !== 1'b1);
      I_PSEL <= 1'b0; I_PENABLE <= 1'b0;
      @(posedge I_CLK);
   endtask
   task automatic rd(input logic [31:0] a, e, m);
      exp_q.push_back(e); msk_q.push_back(m);
      xfer(1'b0, a, 32'h0);
   endtask
   task automatic see_irq(input logic e);
      comparisons++;
      if (O_IRQ !== e) begin bad_count++; $display("MISMATCH %0t irq", $time); end
   endtask
   // watcher: each finished read is judged against the oldest note
   always @(posedge I_CLK) if (I_PSEL && I_PENABLE && !I_PWRITE && O_PREADY === 1'b1 && exp_q.size() > 0) begin
      comparisons++;
      if ((O_PRDATA & msk_q[0]) !== exp_q[0]) begin bad_count++; $display("MISMATCH %0t read", $time); end
      void'(exp_q.pop_front()); void'(msk_q.pop_front());
   end
   // limit 3 gives 64 clocks a wrap; waits sit mid-interval so tallies are exact
   initial begin
      void'($urandom(32'hcfb4));
      repeat (16) @(posedge I_CLK);
      I_RST_N <= 1'b1;
      @(posedge I_CLK);
      rd(32'h0, 32'h000fffff, ALL);
      for (int a = 4; a <= 16; a += 4) rd(32'(a), 32'h0, ALL);
      k = $urandom_range(3, 1);
      xfer(1'b1, 32'h10, $urandom()); // a write to a hole must not land
      xfer(1'b1, 32'h0, 32'h03000003);
      repeat (64 * k + 16) @(posedge I_CLK);
      rd(32'hc, 32'(k) << 20, TAL);
      rd(32'hc, 32'(k) << 20, TAL);
      rd(32'h4, 32'h1, ALL);
      see_irq(1'b1);
      rd(32'h8, 32'(k) << 20, TAL);
      rd(32'hc, 32'h0, TAL);
      rd(32'h4, 32'h0, ALL);
      see_irq(1'b0);
      I_DEBUG_HALT <= 1'b1;
      xfer(1'b1, 32'h0, 32'h02000005);
      repeat (200) @(posedge I_CLK);
      rd(32'hc, 32'h0, TAL);
      I_DEBUG_HALT <= 1'b0;
      repeat (200) @(posedge I_CLK);
      rd(32'h8, 32'h00100000, ALL);
      rd(32'hc, 32'h0, ALL);
      rd(32'h0, 32'h02000005, ALL);
      complete_run();
   end
   initial begin
      #200000;
      bad_count++;
      complete_run();
   end
endmodule
`default_nettype wire
